//--- rtl/tcu_pkg.sv
// Constants, field layout and types of the three-timer counter unit
package tcu_pkg;
    // ==================================================
    // Register byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] A_MODE  = 8'h00;
    localparam logic [7:0] A_CTRL  = 8'h04;
    localparam logic [7:0] A_CLK   = 8'h08;
    localparam logic [7:0] A_CNT0  = 8'h0C;
    localparam logic [7:0] A_CNT1  = 8'h10;
    localparam logic [7:0] A_T2CTL = 8'h14;
    localparam logic [7:0] A_THIRD_TIMER_MODE_REGISTER = 8'h18;
    localparam logic [7:0] A_CNT2  = 8'h1C;
    localparam logic [7:0] A_CAP   = 8'h20;
    // ==================================================
    // Field positions
    localparam int unsigned F_M0   = 0;
    localparam int unsigned F_CT0  = 2;
    localparam int unsigned F_GT0  = 3;
    localparam int unsigned F_M1   = 4;
    localparam int unsigned F_CT1  = 6;
    localparam int unsigned F_GT1  = 7;
    localparam int unsigned F_TR0  = 4;
    localparam int unsigned F_TF0  = 5;
    localparam int unsigned F_TR1  = 6;
    localparam int unsigned F_TF1  = 7;
    localparam int unsigned F_TB0  = 3;
    localparam int unsigned F_TB1  = 4;
    localparam int unsigned F_TB2  = 5;
    localparam int unsigned F_CPRL = 0;
    localparam int unsigned F_CT2  = 1;
    localparam int unsigned F_TR2  = 2;
    localparam int unsigned F_EXEN = 3;
    localparam int unsigned F_TXB  = 4;
    localparam int unsigned F_RXB  = 5;
    localparam int unsigned F_EXF  = 6;
    localparam int unsigned F_TF2  = 7;
    localparam int unsigned F_DIRECTION_COUNT_ENABLE = 0;
    localparam int unsigned F_OE   = 1;
    localparam int unsigned F_ACLR = 3;
    // ==================================================
    // Reset values and timing
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0]  DIV_SLOW = 4'hC;
    localparam logic [3:0]  DIV_FAST = 4'h4;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;
    // ==================================================
    // Counting modes of the first two timers
    typedef enum logic [1:0] {
        TCU_M13,
        TCU_M16,
        TCU_M8RL,
        TCU_MSPLIT
    } tcu_mode_t;
endpackage : tcu_pkg

//--- rtl/tcu_top.sv
// Three-timer counter unit with an AXI4-Lite register slave
`timescale 1ns/1ps
// Function
// [RULE1] Prescaled mode counts high byte plus five low bits of low byte.
// [RULE2] Prescaled high byte steps on low bit four falling; wrap sets overflow flag.
// [RULE3] First two timers count only when run set and gate off or pin high.
// [RULE4] Source select: internal ticks, or falling edges of the timer's event pin.
// [RULE5] Thirteen-bit count 1FFFh rolls to 0000h, setting overflow flag.
// [RULE6] Internal count rate is clock over 12 or 4 per time-base bit.
// [RULE7] Sixteen-bit mode wraps FFFFh to 0000h and sets overflow flag.
// [RULE8] Auto-reload: low byte wraps, reloads from high byte, sets overflow flag.
// [RULE9] Second timer in split mode holds its count.
// [RULE10] Split first timer: low byte own controls, high byte uses second's run/flag.
// [RULE11] With first timer split, second runs without run bit and flag.
// [RULE12] Third timer counts pin edges or divided clock, only while run set.
// [RULE13] Capture mode counts up; FFFFh rollover sets third overflow flag.
// [RULE14] Trigger falling edge captures count and sets trigger flag when enabled.
// [RULE15] Auto-clear bit clears third count after each capture.
// [RULE16] Up reload mode reloads from capture pair on rollover or trigger edge.
// [RULE17] Up/down mode: pin high counts up; down at capture value loads FFFFh.
// [RULE18] Up/down reloads set overflow flag, toggle trigger flag, no trigger request.
// [RULE19] Baud selects make third timer auto-reload without setting overflow flag.
// [RULE20] Baud mode trigger falling edge sets trigger flag and requests interrupt.
// [RULE21] Output enable with both selects clear and run drives 50% clock.
// [RULE22] Clock-out rate is clock over four times 65536 minus capture pair.
// [RULE23] Event pins sampled once per machine cycle; fall is high then low.
// [RULE24] Reset clears all three time-base bits, giving clock over twelve.
// [RULE25] Disabled timers hold counts; software writes apply at once. Third timer trigger edge still reloads or auto-clears its count.
module tcu_top (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic [1:0]       o_bresp,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    input  wire logic        i_event_a,
    input  wire logic        i_event_b,
    input  wire logic        i_ext_int_a,
    input  wire logic        i_ext_int_b,
    input  wire logic        i_t2_event,
    input  wire logic        i_t2_trig,
    output logic             o_tf0,
    output logic             o_tf1,
    output logic             o_t2_irq,
    output logic             o_t1_ovf,
    output logic             o_t2_ovf,
    output logic             o_clk_out,
    output logic             o_clk_out_en
);
    // ==================================================
    // Functions
    function automatic logic [16:0] tcu_step(input tcu_pkg::tcu_mode_t m,
                                             input logic [15:0] c);
        logic [16:0] r;
        r = {1'b0, c};
        case (m)
            tcu_pkg::TCU_M13: begin
                r[4:0] = c[4:0] + 5'h01;
                if (c[4:0] == 5'h1F) begin
                    r[15:8] = c[15:8] + 8'h01;
                    r[16]   = (c[15:8] == 8'hFF);
                end
            end
            tcu_pkg::TCU_M16: r = {1'b0, c} + 17'h00001;
            tcu_pkg::TCU_M8RL: begin
                r[7:0] = (c[7:0] == 8'hFF) ? c[15:8] : c[7:0] + 8'h01;
                r[16]  = (c[7:0] == 8'hFF);
            end
            default: r = {1'b0, c};
        endcase
        return r;
    endfunction : tcu_step

    function automatic logic tcu_hit(input logic [7:0] a);
        return a inside {tcu_pkg::A_MODE, tcu_pkg::A_CTRL, tcu_pkg::A_CLK,
                         tcu_pkg::A_CNT0, tcu_pkg::A_CNT1, tcu_pkg::A_T2CTL,
                         tcu_pkg::A_THIRD_TIMER_MODE_REGISTER, tcu_pkg::A_CNT2, tcu_pkg::A_CAP};
    endfunction : tcu_hit

    // ==================================================
    // State
    logic [7:0]  mode_q, aw_q;
    logic        tr0_q, tr1_q, tf0_q, tf1_q, tb0_q, tb1_q, tb2_q;
    logic [15:0] c0_q, c1_q, c2_q, cap_q, wd_q;
    logic [7:0]  t2ctl_q, third_timer_mode_register_q;
    logic [3:0]  div_q, ws_q;
    logic [5:0]  s1_q, s2_q, smp_q, fall_q;
    logic        awrdy_q, wrdy_q, awv_q, wv_q, bv_q, arrdy_q, rv_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        irq2_q, t1o_q, t2o_q, clk_q, cen_q;

    // ==================================================
    // Dividers: machine cycle is four clocks
    logic tick12, tick4, mc_tick;
    assign tick12  = (div_q == tcu_pkg::DIV_SLOW - 4'h1);
    assign tick4   = (div_q[1:0] == 2'h3);
    assign mc_tick = tick4;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q <= 4'h0;
        end else begin
            div_q <= tick12 ? 4'h0 : div_q + 4'h1; // RULE6
        end
    end

    // ==================================================
    // Pin synchronisers and per-machine-cycle edge sampling
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_q   <= 6'h00;
            s2_q   <= 6'h00;
            smp_q  <= 6'h00;
            fall_q <= 6'h00;
        end else begin
            s1_q <= {i_t2_trig, i_t2_event, i_ext_int_b, i_ext_int_a, i_event_b, i_event_a};
            s2_q <= s1_q;
            if (mc_tick) begin
                smp_q <= s2_q;
            end
            fall_q <= mc_tick ? (smp_q & ~s2_q) : 6'h00; // RULE23
        end
    end

    // ==================================================
    // Register bus decode
    logic wr_go, wr_hit;
    logic w_mode, w_ctrl, w_clk, w_c0, w_c1, w_t2c, w_t2m, w_c2, w_cap;
    assign wr_go  = awv_q & wv_q & ~bv_q;
    assign wr_hit = wr_go & ws_q[0];
    assign w_mode = wr_hit & (aw_q == tcu_pkg::A_MODE);
    assign w_ctrl = wr_hit & (aw_q == tcu_pkg::A_CTRL);
    assign w_clk  = wr_hit & (aw_q == tcu_pkg::A_CLK);
    assign w_t2c  = wr_hit & (aw_q == tcu_pkg::A_T2CTL);
    assign w_t2m  = wr_hit & (aw_q == tcu_pkg::A_THIRD_TIMER_MODE_REGISTER);
    assign w_c0   = wr_go & (aw_q == tcu_pkg::A_CNT0) & |ws_q[1:0];
    assign w_c1   = wr_go & (aw_q == tcu_pkg::A_CNT1) & |ws_q[1:0];
    assign w_c2   = wr_go & (aw_q == tcu_pkg::A_CNT2) & |ws_q[1:0];
    assign w_cap  = wr_go & (aw_q == tcu_pkg::A_CAP) & |ws_q[1:0];

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                          input logic [1:0] s);
        return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction : merge

    // ==================================================
    // First two timers
    tcu_pkg::tcu_mode_t m0, m1;
    logic        split0, inc0, inc1, en0, en1, hi_en, set_tf0, set_tf1;
    logic [16:0] st0, st1;
    logic [15:0] c0_n, c1_n;
    assign m0     = tcu_pkg::tcu_mode_t'(mode_q[tcu_pkg::F_M0 +: 2]);
    assign m1     = tcu_pkg::tcu_mode_t'(mode_q[tcu_pkg::F_M1 +: 2]);
    assign split0 = (m0 == tcu_pkg::TCU_MSPLIT);
    assign inc0   = mode_q[tcu_pkg::F_CT0] ? fall_q[0] : (tb0_q ? tick4 : tick12); // RULE4
    assign inc1   = mode_q[tcu_pkg::F_CT1] ? fall_q[1] : (tb1_q ? tick4 : tick12); // RULE6
    assign en0    = tr0_q & (~mode_q[tcu_pkg::F_GT0] | smp_q[2]); // RULE3
    assign en1    = (split0 | tr1_q) & (~mode_q[tcu_pkg::F_GT1] | smp_q[3]); // RULE11
    assign hi_en  = split0 & tr1_q & (tb0_q ? tick4 : tick12); // RULE10
    assign st0    = tcu_step(m0, c0_q); // RULE1
    assign st1    = tcu_step(m1, c1_q); // RULE9

    always_comb begin
        c0_n    = c0_q;
        set_tf0 = 1'b0;
        set_tf1 = 1'b0;
        if (split0) begin
            if (en0 & inc0) begin
                c0_n[7:0] = c0_q[7:0] + 8'h01; // RULE10
                set_tf0   = (c0_q[7:0] == 8'hFF);
            end
            if (hi_en) begin
                c0_n[15:8] = c0_q[15:8] + 8'h01;
                set_tf1    = (c0_q[15:8] == 8'hFF);
            end
        end else if (en0 & inc0) begin
            c0_n    = st0[15:0]; // RULE2 RULE7 RULE8
            set_tf0 = st0[16]; // RULE5
        end
        c1_n = (en1 & inc1) ? st1[15:0] : c1_q; // RULE25
        if (en1 & inc1 & ~split0 & st1[16]) begin
            set_tf1 = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            c0_q  <= tcu_pkg::RST_WORD;
            c1_q  <= tcu_pkg::RST_WORD;
            t1o_q <= 1'b0;
        end else begin
            c0_q  <= w_c0 ? merge(c0_q, wd_q, ws_q[1:0]) : c0_n; // RULE25
            c1_q  <= w_c1 ? merge(c1_q, wd_q, ws_q[1:0]) : c1_n;
            t1o_q <= en1 & inc1 & st1[16];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_q <= tcu_pkg::RST_BYTE;
            {tr0_q, tr1_q, tf0_q, tf1_q} <= 4'h0;
            {tb0_q, tb1_q, tb2_q} <= 3'h0; // RULE24
        end else begin
            if (w_mode) begin
                mode_q <= wd_q[7:0];
            end
            if (w_ctrl) begin
                tr0_q <= wd_q[tcu_pkg::F_TR0];
                tr1_q <= wd_q[tcu_pkg::F_TR1];
            end
            if (w_clk) begin
                tb0_q <= wd_q[tcu_pkg::F_TB0];
                tb1_q <= wd_q[tcu_pkg::F_TB1];
                tb2_q <= wd_q[tcu_pkg::F_TB2];
            end
            tf0_q <= set_tf0 | (w_ctrl ? wd_q[tcu_pkg::F_TF0] : tf0_q);
            tf1_q <= set_tf1 | (w_ctrl ? wd_q[tcu_pkg::F_TF1] : tf1_q);
        end
    end

    // ==================================================
    // Third timer
    logic        cprl, ct2, tr2, exen, baud, clkout, updn, inc2, trg, dir;
    logic        s_tf2, s_exf, t_exf, ov2;
    logic [15:0] c2_n, cap_n;
    assign cprl   = t2ctl_q[tcu_pkg::F_CPRL];
    assign ct2    = t2ctl_q[tcu_pkg::F_CT2];
    assign tr2    = t2ctl_q[tcu_pkg::F_TR2];
    assign exen   = t2ctl_q[tcu_pkg::F_EXEN];
    assign baud   = t2ctl_q[tcu_pkg::F_TXB] | t2ctl_q[tcu_pkg::F_RXB];
    assign clkout = third_timer_mode_register_q[tcu_pkg::F_OE] & ~ct2 & ~cprl; // RULE21
    assign updn   = ~cprl & ~baud & ~clkout & third_timer_mode_register_q[tcu_pkg::F_DIRECTION_COUNT_ENABLE];
    assign inc2   = tr2 & (ct2 ? fall_q[4] : clkout ? div_q[0] : (tb2_q ? tick4 : tick12)); // RULE12 RULE22
    assign trg    = exen & fall_q[5];
    assign dir    = smp_q[5];

    always_comb begin
        c2_n  = c2_q;
        cap_n = cap_q;
        s_tf2 = 1'b0;
        s_exf = 1'b0;
        t_exf = 1'b0;
        ov2   = 1'b0;
        if (cprl & ~baud) begin
            if (inc2) begin
                {ov2, c2_n} = {1'b0, c2_q} + 17'h00001; // RULE13
                s_tf2       = ov2;
            end
            if (trg) begin
                cap_n = c2_q; // RULE14
                s_exf = 1'b1;
                if (third_timer_mode_register_q[tcu_pkg::F_ACLR]) begin
                    c2_n = tcu_pkg::RST_WORD; // RULE15
                end
            end
        end else if (updn) begin
            if (inc2 & dir) begin
                ov2  = (c2_q == 16'hFFFF); // RULE17
                c2_n = ov2 ? cap_q : c2_q + 16'h0001;
            end else if (inc2) begin
                ov2  = (c2_q == cap_q);
                c2_n = ov2 ? 16'hFFFF : c2_q - 16'h0001;
            end
            s_tf2 = ov2; // RULE18
            t_exf = ov2;
        end else begin
            if (inc2) begin
                ov2  = (c2_q == 16'hFFFF); // RULE16 RULE19
                c2_n = ov2 ? cap_q : c2_q + 16'h0001;
            end
            s_tf2 = ov2 & ~baud & ~clkout; // RULE19
            if (trg) begin
                s_exf = 1'b1; // RULE20
                if (~baud & ~clkout) begin
                    c2_n = cap_q; // RULE16
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            c2_q    <= tcu_pkg::RST_WORD;
            cap_q   <= tcu_pkg::RST_WORD;
            t2ctl_q <= tcu_pkg::RST_BYTE;
            third_timer_mode_register_q <= tcu_pkg::RST_BYTE;
        end else begin
            c2_q  <= w_c2 ? merge(c2_q, wd_q, ws_q[1:0]) : c2_n;
            cap_q <= w_cap ? merge(cap_q, wd_q, ws_q[1:0]) : cap_n;
            if (w_t2c) begin
                t2ctl_q[5:0] <= wd_q[5:0];
            end
            t2ctl_q[tcu_pkg::F_TF2] <= s_tf2 | (w_t2c ? wd_q[tcu_pkg::F_TF2]
                                                      : t2ctl_q[tcu_pkg::F_TF2]);
            t2ctl_q[tcu_pkg::F_EXF] <= s_exf | ((w_t2c ? wd_q[tcu_pkg::F_EXF]
                                                       : t2ctl_q[tcu_pkg::F_EXF]) ^ t_exf);
            if (w_t2m) begin
                third_timer_mode_register_q <= wd_q[7:0] & 8'h0B;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {irq2_q, t2o_q, clk_q, cen_q} <= 4'h0;
        end else begin
            irq2_q <= t2ctl_q[tcu_pkg::F_TF2] | (t2ctl_q[tcu_pkg::F_EXF] & ~updn); // RULE18
            t2o_q  <= ov2;
            cen_q  <= clkout;
            if (~clkout) begin
                clk_q <= 1'b0;
            end else if (ov2) begin
                clk_q <= ~clk_q; // RULE21
            end
        end
    end

    // ==================================================
    // AXI4-Lite slave: one write and one read in flight
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {awrdy_q, wrdy_q, awv_q, wv_q, bv_q} <= 5'h00;
            aw_q    <= 8'h00;
            wd_q    <= tcu_pkg::RST_WORD;
            ws_q    <= 4'h0;
            bresp_q <= tcu_pkg::RESP_OK;
        end else begin
            if (awrdy_q & i_awvalid) begin
                awrdy_q <= 1'b0;
                awv_q   <= 1'b1;
                aw_q    <= i_awaddr;
            end else if (~awv_q & ~bv_q) begin
                awrdy_q <= 1'b1;
            end
            if (wrdy_q & i_wvalid) begin
                wrdy_q <= 1'b0;
                wv_q   <= 1'b1;
                wd_q   <= i_wdata[15:0];
                ws_q   <= i_wstrb;
            end else if (~wv_q & ~bv_q) begin
                wrdy_q <= 1'b1;
            end
            if (wr_go) begin
                bv_q    <= 1'b1;
                awv_q   <= 1'b0;
                wv_q    <= 1'b0;
                bresp_q <= tcu_hit(aw_q) ? tcu_pkg::RESP_OK : tcu_pkg::RESP_ERR;
            end else if (bv_q & i_bready) begin
                bv_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {arrdy_q, rv_q} <= 2'h0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= tcu_pkg::RESP_OK;
        end else if (arrdy_q & i_arvalid) begin
            arrdy_q <= 1'b0;
            rv_q    <= 1'b1;
            rresp_q <= tcu_hit(i_araddr) ? tcu_pkg::RESP_OK : tcu_pkg::RESP_ERR;
            case (i_araddr)
                tcu_pkg::A_MODE:  rdata_q <= {24'h0, mode_q};
                tcu_pkg::A_CTRL:  rdata_q <= {24'h0, tf1_q, tr1_q, tf0_q, tr0_q, 4'h0};
                tcu_pkg::A_CLK:   rdata_q <= {26'h0, tb2_q, tb1_q, tb0_q, 3'h0};
                tcu_pkg::A_CNT0:  rdata_q <= {16'h0, c0_q};
                tcu_pkg::A_CNT1:  rdata_q <= {16'h0, c1_q};
                tcu_pkg::A_T2CTL: rdata_q <= {24'h0, t2ctl_q};
                tcu_pkg::A_THIRD_TIMER_MODE_REGISTER: rdata_q <= {24'h0, third_timer_mode_register_q};
                tcu_pkg::A_CNT2:  rdata_q <= {16'h0, c2_q};
                tcu_pkg::A_CAP:   rdata_q <= {16'h0, cap_q};
                default:          rdata_q <= 32'h0000_0000;
            endcase
        end else if (rv_q & i_rready) begin
            rv_q <= 1'b0;
        end else if (~rv_q) begin
            arrdy_q <= 1'b1;
        end
    end

    assign o_awready    = awrdy_q;
    assign o_wready     = wrdy_q;
    assign o_bvalid     = bv_q;
    assign o_bresp      = bresp_q;
    assign o_arready    = arrdy_q;
    assign o_rvalid     = rv_q;
    assign o_rdata      = rdata_q;
    assign o_rresp      = rresp_q;
    assign o_tf0        = tf0_q;
    assign o_tf1        = tf1_q;
    assign o_t2_irq     = irq2_q;
    assign o_t1_ovf     = t1o_q;
    assign o_t2_ovf     = t2o_q;
    assign o_clk_out    = clk_q;
    assign o_clk_out_en = cen_q;

    // ==================================================
    // Assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    div_rate_a: assert property (tick12 |-> ##12 tick12) else $error("slow tick period"); // RULE6
    m13_carry_a: assert property ((m0 == tcu_pkg::TCU_M13) && en0 && inc0 && !w_c0 // RULE2
        && c0_q[4:0] == 5'h1F |=> c0_q[15:8] == $past(c0_q[15:8]) + 8'h01)
        else $error("prescaled carry missed");
    m13_wrap_a: assert property ((m0 == tcu_pkg::TCU_M13) && en0 && inc0 && !w_c0 // RULE5
        && c0_q[15:8] == 8'hFF && c0_q[4:0] == 5'h1F |=> tf0_q && c0_q[15:8] == 8'h00
        && c0_q[4:0] == 5'h00) else $error("13-bit rollover wrong");
    gate_hold_a: assert property (!en0 && !split0 && !w_c0 |=> $stable(c0_q)) // RULE3
        else $error("gated timer moved");
    reload8_a: assert property ((m0 == tcu_pkg::TCU_M8RL) && en0 && inc0 && !w_c0 // RULE8
        && c0_q[7:0] == 8'hFF |=> tf0_q && c0_q[7:0] == $past(c0_q[15:8]))
        else $error("8-bit reload wrong");
    split_freeze_a: assert property ((m1 == tcu_pkg::TCU_MSPLIT) && !w_c1 // RULE9
        |=> $stable(c1_q)) else $error("split second timer moved");
    capture_take_a: assert property (cprl && !baud && trg && !w_cap // RULE14
        |=> cap_q == $past(c2_q) && t2ctl_q[tcu_pkg::F_EXF]) else $error("capture missed");
    baud_noflag_a: assert property (baud && !t2ctl_q[tcu_pkg::F_TF2] && !w_t2c // RULE19
        |=> !t2ctl_q[tcu_pkg::F_TF2]) else $error("baud rollover set flag");
    clkout_toggle_a: assert property (clkout && cen_q && ov2 // RULE21
        |=> o_clk_out != $past(o_clk_out)) else $error("clock-out did not toggle");
endmodule : tcu_top

//--- sim/tcu_pins_model.sv
// Pin model: event, gate and trigger inputs of the timer unit
`timescale 1ns/1ps
module tcu_pins_model (
    input  wire logic i_clk,
    output logic      o_event_a,
    output logic      o_event_b,
    output logic      o_ext_int_a,
    output logic      o_ext_int_b,
    output logic      o_t2_event,
    output logic      o_t2_trig
);
    initial {o_event_a, o_event_b, o_ext_int_a, o_ext_int_b, o_t2_event, o_t2_trig} = 6'h3F;
    task automatic gate_a(input logic v);
        @(posedge i_clk);
        o_ext_int_a <= v;
    endtask : gate_a
    // Each level lasts two machine cycles so every fall is seen
    task automatic pulse_a(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_event_a <= 1'b0;
            repeat (8) @(posedge i_clk);
            o_event_a <= 1'b1;
            repeat (7) @(posedge i_clk);
        end
    endtask : pulse_a
    task automatic trig_fall;
        @(posedge i_clk);
        o_t2_trig <= 1'b0;
        repeat (8) @(posedge i_clk);
        o_t2_trig <= 1'b1;
    endtask : trig_fall
endmodule : tcu_pins_model

//--- sim/testbench.sv
// Self-checking bench for the three-timer counter unit
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 1'b0, i_rstn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
    logic        i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, b;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd;
    logic [3:0]  i_wstrb = 4'hF;
    logic [1:0]  o_bresp, o_rresp, rr;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tf0, o_tf1;
    logic        i_event_a, i_event_b, i_ext_int_a, i_ext_int_b, i_t2_event, i_t2_trig;
    logic        o_t2_irq, o_t1_ovf, o_t2_ovf, o_clk_out, o_clk_out_en;
    int          num_errors = 0, tests_run = 0, n;
    always #20 i_clk = ~i_clk;
    tcu_top u_dut (.i_clk, .i_rstn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
        .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
        .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_event_a, .i_event_b, .i_ext_int_a,
        .i_ext_int_b, .i_t2_event, .i_t2_trig, .o_tf0, .o_tf1, .o_t2_irq, .o_t1_ovf,
        .o_t2_ovf, .o_clk_out, .o_clk_out_en);
    tcu_pins_model u_pins (.i_clk, .o_event_a(i_event_a), .o_event_b(i_event_b),
        .o_ext_int_a(i_ext_int_a), .o_ext_int_b(i_ext_int_b), .o_t2_event(i_t2_event),
        .o_t2_trig(i_t2_trig));
    // ==================================================
    // Bus and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_awaddr  <= a;
        i_wdata   <= d;
        i_bready  <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge i_clk);
        i_arvalid <= 1'b1;
        i_araddr  <= a;
        i_rready  <= 1'b1;
        do begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        rd = o_rdata;
        rr = o_rresp;
        i_rready <= 1'b0;
    endtask : rdr
    task automatic stop_test;
        $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // ==================================================
    // Scenarios
    task automatic t_rate(input int exp);
        wr(tcu_pkg::A_MODE, 32'h1);
        wr(tcu_pkg::A_CNT0, 32'h0);
        wr(tcu_pkg::A_CTRL, 32'h10);
        repeat (1200) @(posedge i_clk);
        wr(tcu_pkg::A_CTRL, 32'h0);
        rdr(tcu_pkg::A_CNT0);
        chk(rd + 2 >= exp && rd <= exp + 2, 1);
    endtask : t_rate
    task automatic t_wrap(input logic [31:0] m, input logic [31:0] init, input logic [31:0] exp);
        wr(tcu_pkg::A_MODE, m);
        wr(tcu_pkg::A_CNT0, init);
        wr(tcu_pkg::A_CTRL, 32'h10);
        n = 0;
        while (o_tf0 !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        chk(o_tf0, 1);
        wr(tcu_pkg::A_CTRL, 32'h0);
        rdr(tcu_pkg::A_CNT0);
        chk(rd, exp);
    endtask : t_wrap
    task automatic t_misc;
        wr(tcu_pkg::A_MODE, 32'h09);
        wr(tcu_pkg::A_CNT0, 32'h0);
        u_pins.gate_a(1'b0);
        wr(tcu_pkg::A_CTRL, 32'h10);
        repeat (200) @(posedge i_clk);
        rdr(tcu_pkg::A_CNT0);
        chk(rd, 0);
        u_pins.gate_a(1'b1);
        repeat (200) @(posedge i_clk);
        rdr(tcu_pkg::A_CNT0);
        chk(rd != 0, 1);
        wr(tcu_pkg::A_MODE, 32'h05);
        wr(tcu_pkg::A_CNT0, 32'h0);
        u_pins.pulse_a(5);
        repeat (20) @(posedge i_clk);
        rdr(tcu_pkg::A_CNT0);
        chk(rd, 5);
        wr(tcu_pkg::A_CNT2, 32'h1234);
        wr(tcu_pkg::A_THIRD_TIMER_MODE_REGISTER, 32'h08);
        wr(tcu_pkg::A_T2CTL, 32'h09);
        u_pins.trig_fall();
        repeat (20) @(posedge i_clk);
        chk(o_t2_irq, 1);
        rdr(tcu_pkg::A_CAP);
        chk(rd, 32'h1234);
        rdr(tcu_pkg::A_CNT2);
        chk(rd, 0);
        wr(tcu_pkg::A_T2CTL, 32'h0);
        wr(tcu_pkg::A_THIRD_TIMER_MODE_REGISTER, 32'h02);
        wr(tcu_pkg::A_CAP, 32'hFFFE);
        wr(tcu_pkg::A_CNT2, 32'hFFFE);
        wr(tcu_pkg::A_T2CTL, 32'h04);
        repeat (2) begin
            b = o_clk_out;
            n = 0;
            while (o_clk_out === b && n < 100) begin
                @(posedge i_clk);
                n++;
            end
        end
        chk(n, 4);
        n = 0;
        while (o_t2_ovf !== 1'b1 && n < 10) begin
            @(posedge i_clk);
            n++;
        end
        chk(o_t2_ovf, 1);
        chk({o_clk_out_en, o_t2_irq}, 2);
        rdr(8'hFC);
        chk(rr, tcu_pkg::RESP_ERR);
    endtask : t_misc
    task automatic t_t1;
        wr(tcu_pkg::A_MODE, 32'h10);
        wr(tcu_pkg::A_CNT1, 32'hFFFF);
        wr(tcu_pkg::A_CTRL, 32'h40);
        b = 1'b0;
        n = 0;
        while (o_tf1 !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            b = b | (o_t1_ovf === 1'b1);
            n++;
        end
        chk(o_tf1, 1);
        chk(b, 1);
        wr(tcu_pkg::A_CTRL, 32'h0);
    endtask : t_t1
    initial begin
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_rate(101);
        wr(tcu_pkg::A_CLK, 32'h08);
        t_rate(301);
        wr(tcu_pkg::A_CLK, 32'h0);
        t_wrap(1, 32'hFFFF, 0);
        t_wrap(0, 32'hFF1F, 0);
        t_wrap(2, 32'h55FF, 32'h5555);
        t_t1();
        t_misc();
        stop_test();
    end
    initial begin
        #1ms;
        num_errors++;
        stop_test();
    end
endmodule : testbench
